// ### pag_guard.sv
// parameter write/read/display guard with direction limit
`timescale 1ns/100ps
`default_nettype none

// What this block does
// (R1) policy 0: write only stopped, panel mode
// (R2) policy 0: frequency settings writable running, panel
// (R3) policy 1: refuse writes except listed ones
// (R4) policy 1: reject both clear commands
// (R5) policy 1: listed exception parameters stay writable
// (R6) policy 2: writes accepted in any state
// (R7) policy 2: running-locked list refused while running
// (R8) write policy writable in every mode
// (R9) policy/direction settable only with extended scope
// (R10) direction limit 0 both, 1 noRev, 2 noFwd
// (R11) direction limit gates every start source
// (R12) scope 9999 simple only, 0 all
// (R13) display scope changeable anytime under policy 0
// (R14) serial reads ignore scope unless source 2
// (R15) handheld attached: jog and contrast simple
// (R16) source 9999: handheld outranks built-in panel
// (R17) outside party avoids reset with start active
// (R18) refused write keeps value, reports refusal
module pag_guard
    import pag_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_op,
    input  wire logic [1:0]  req_src,
    input  wire logic [15:0] req_param,
    input  wire logic [15:0] req_wdata,
    input  wire logic        req_param_simple,
    input  wire logic        req_param_shaded,
    input  wire logic        motor_running,
    input  wire logic        panel_mode,
    input  wire logic        handheld_attached,
    input  wire logic [15:0] panel_command_source_select,
    input  wire logic        panel_fwd_key,
    input  wire logic        panel_rev_key,
    input  wire logic        handheld_fwd_key,
    input  wire logic        handheld_rev_key,
    input  wire logic        forward_start_input,
    input  wire logic        reverse_start_input,
    input  wire logic        serial_fwd_cmd,
    input  wire logic        serial_rev_cmd,
    output logic             resp_valid,
    output logic             resp_ok,
    output logic             resp_refused,
    output logic [15:0]      resp_rdata,
    output logic             ext_write_strobe,
    output logic [15:0]      ext_write_param,
    output logic [15:0]      ext_write_data,
    output logic             ext_clear_strobe,
    output logic             ext_all_clear_strobe,
    output logic             run_fwd,
    output logic             run_rev,
    output logic             handheld_owns_panel,
    output logic [15:0]      write_policy,
    output logic [15:0]      direction_limit,
    output logic [15:0]      display_scope
);

    // parameters that cannot change while running under policy 2
    function automatic logic run_locked(input logic [15:0] p);
        unique case (p)
            16'h0017,
            16'h0028,
            16'h0030,
            16'h003C,
            16'h0042,
            16'h0047,
            16'h004F,
            16'h0050,
            16'h0052,
            16'h0053,
            16'h0054,
            16'h005A,
            16'h0060,
            16'h00B2,
            16'h00B3,
            16'h00B4,
            16'h00B5,
            16'h00B6,
            16'h00BE,
            16'h00C0,
            16'h00C5,
            16'h0105,
            16'h012A,
            16'h01C2,
            16'h0231: run_locked = 1'b1;
            default:  run_locked = 1'b0;
        endcase
    endfunction

    // writable in any mode and state under policy 0
    function automatic logic free_write(input logic [15:0] p);
        unique case (p)
            PAG_P_WRITE_POLICY,
            PAG_P_DISPLAY_SCOPE,
            PAG_P_RESET_SEL,
            PAG_P_PW_LEVEL,
            PAG_P_PW_LOCK: free_write = 1'b1;
            default:       free_write = 1'b0;
        endcase
    endfunction

    // still writable under policy 1
    function automatic logic lock_exempt(input logic [15:0] p);
        unique case (p)
            PAG_P_STALL_LEVEL,
            PAG_P_RESET_SEL,
            PAG_P_WRITE_POLICY,
            PAG_P_OP_MODE,
            PAG_P_DISPLAY_SCOPE,
            PAG_P_PW_LEVEL,
            PAG_P_PW_LOCK: lock_exempt = 1'b1;
            default:       lock_exempt = 1'b0;
        endcase
    endfunction

    logic is_policy;
    logic is_dirlim;
    logic is_scope;
    logic internal;
    logic anytime;
    logic exempt_locked;
    logic value_ok;
    logic scope_ok;
    logic write_allow;
    logic clear_allow;
    logic read_allow;
    logic treat_simple;
    logic next_ok;
    logic [15:0] next_rdata;
    logic is_pwm;
    logic rd_req;
    logic wr_req;
    logic clr_req;
    logic all_clr_req;
    logic wr_take;
    logic clr_take;

    assign is_policy = (req_param == PAG_P_WRITE_POLICY);
    assign is_dirlim = (req_param == PAG_P_DIR_LIMIT);
    assign is_scope  = (req_param == PAG_P_DISPLAY_SCOPE);
    assign internal  = is_policy | is_dirlim | is_scope;
    assign is_pwm    = (req_param == PAG_P_SW_FREQ) || (req_param == PAG_P_SOFT_SW);

    assign rd_req      = req_valid && (req_op == PAG_OP_READ);
    assign wr_req      = req_valid && (req_op == PAG_OP_WRITE);
    assign clr_req     = req_valid && (req_op == PAG_OP_CLEAR);
    assign all_clr_req = req_valid && (req_op == PAG_OP_ALL_CLEAR);

    // shaded lookup never frees the two pwm settings
    assign anytime = free_write(req_param)                                // [R8] [R13]
                   || (req_param_shaded && !is_pwm);                      // [R2]

    assign exempt_locked = lock_exempt(req_param);                        // [R5]

    // only legal codes may be stored
    always_comb begin
        value_ok = 1'b1;
        if (is_policy) begin
            value_ok = (req_wdata <= PAG_WP_ANY);
        end else if (is_dirlim) begin
            value_ok = (req_wdata <= PAG_DL_NO_FWD);                      // [R10]
        end else if (is_scope) begin
            value_ok = (req_wdata == PAG_DS_EXTENDED) || (req_wdata == PAG_DS_SIMPLE);
        end
    end

    assign scope_ok = !(is_policy || is_dirlim) || (display_scope == PAG_DS_EXTENDED); // [R9]

    always_comb begin
        write_allow = 1'b0;
        unique case (write_policy)
            PAG_WP_STOP_ONLY: begin
                write_allow = (!motor_running && panel_mode)              // [R1]
                            || anytime
                            || (panel_mode && is_pwm);                    // [R2]
            end
            PAG_WP_LOCKED: begin
                write_allow = exempt_locked;                              // [R3] [R5]
            end
            PAG_WP_ANY: begin
                write_allow = !(motor_running && run_locked(req_param));  // [R6] [R7]
            end
            default: write_allow = 1'b0;
        endcase
        if (is_policy) begin
            write_allow = 1'b1;                                           // [R8]
        end
        write_allow = write_allow && scope_ok && value_ok;
    end

    // clears refused under policy 1; all clear never while running
    always_comb begin
        clear_allow = (write_policy != PAG_WP_LOCKED);                    // [R4]
        if (req_op == PAG_OP_ALL_CLEAR) begin
            clear_allow = clear_allow && !motor_running;
        end
    end

    assign wr_take  = wr_req && write_allow;
    assign clr_take = (clr_req || all_clr_req) && clear_allow;

    assign treat_simple = req_param_simple
                        || (handheld_attached && ((req_param == PAG_P_JOG_FREQ)
                            || (req_param == PAG_P_JOG_RAMP)
                            || (req_param == PAG_P_CONTRAST)));           // [R15]

    always_comb begin
        read_allow = treat_simple || (display_scope == PAG_DS_EXTENDED);  // [R12]
        if ((req_src == PAG_SRC_SERIAL)
            && (panel_command_source_select != PAG_PCS_SERIAL)) begin
            read_allow = 1'b1;                                            // [R14]
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        if (is_policy) begin
            next_rdata = write_policy;
        end else if (is_dirlim) begin
            next_rdata = direction_limit;
        end else if (is_scope) begin
            next_rdata = display_scope;
        end
    end

    always_comb begin
        unique case (req_op)
            PAG_OP_READ:  next_ok = read_allow;
            PAG_OP_WRITE: next_ok = write_allow;
            default:      next_ok = clear_allow;
        endcase
    end

    // answer one cycle after each request
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_valid   <= 1'b0;
            resp_ok      <= 1'b0;
            resp_refused <= 1'b0;
        end else begin
            resp_valid   <= req_valid;
            resp_ok      <= req_valid && next_ok;
            resp_refused <= req_valid && !next_ok;                        // [R18]
        end
    end

    // read data only for an accepted read of a local setting
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_rdata <= 16'h0000;
        end else begin
            resp_rdata <= (rd_req && read_allow) ? next_rdata : 16'h0000;
        end
    end

    // accepted writes and clears for the external parameter store
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_write_strobe     <= 1'b0;
            ext_clear_strobe     <= 1'b0;
            ext_all_clear_strobe <= 1'b0;
        end else begin
            ext_write_strobe     <= wr_take && !internal;                 // [R18]
            ext_clear_strobe     <= clr_req && clear_allow;
            ext_all_clear_strobe <= all_clr_req && clear_allow;           // [R4]
        end
    end

    // last write request, held for the store to pick up
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_write_param <= 16'h0000;
            ext_write_data  <= 16'h0000;
        end else if (wr_req) begin
            ext_write_param <= req_param;
            ext_write_data  <= req_wdata;
        end
    end

    // write policy survives both clears
    always_ff @(posedge clk) begin
        if (rst) begin
            write_policy <= PAG_RST_WRITE_POLICY;
        end else if (wr_take && is_policy) begin
            write_policy <= req_wdata;                                    // [R8]
        end
    end

    // clears return direction limit to both directions
    always_ff @(posedge clk) begin
        if (rst) begin
            direction_limit <= PAG_RST_DIR_LIMIT;
        end else if (wr_take && is_dirlim) begin
            direction_limit <= req_wdata;                                 // [R9]
        end else if (clr_take) begin
            direction_limit <= PAG_RST_DIR_LIMIT;
        end
    end

    // clears return display scope to simple view
    always_ff @(posedge clk) begin
        if (rst) begin
            display_scope <= PAG_RST_DISPLAY_SCOPE;
        end else if (wr_take && is_scope) begin
            display_scope <= req_wdata;                                   // [R13]
        end else if (clr_take) begin
            display_scope <= PAG_RST_DISPLAY_SCOPE;
        end
    end

    // start commands from every source, panel keys from the owning unit only
    logic owner_hh;
    logic panel_fwd_sel;
    logic panel_rev_sel;
    logic fwd_any;
    logic rev_any;

    assign owner_hh = (panel_command_source_select == PAG_PCS_AUTO)
                    && handheld_attached;                                 // [R16]
    assign panel_fwd_sel = owner_hh ? handheld_fwd_key : panel_fwd_key;   // [R16]
    assign panel_rev_sel = owner_hh ? handheld_rev_key : panel_rev_key;   // [R16]
    assign fwd_any = panel_fwd_sel || forward_start_input || serial_fwd_cmd; // [R11]
    assign rev_any = panel_rev_sel || reverse_start_input || serial_rev_cmd; // [R11]

    // the limit masks each direction after all sources are merged
    always_ff @(posedge clk) begin
        if (rst) begin
            run_fwd <= 1'b0;
            run_rev <= 1'b0;
        end else begin
            run_fwd <= fwd_any && (direction_limit != PAG_DL_NO_FWD);     // [R10] [R11]
            run_rev <= rev_any && (direction_limit != PAG_DL_NO_REV);     // [R10] [R11]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            handheld_owns_panel <= 1'b0;
        end else begin
            handheld_owns_panel <= owner_hh;                              // [R16]
        end
    end

endmodule
`default_nettype wire

// ### pag_pkg.sv
// constants for the parameter access guard
package pag_pkg;

    localparam int PAG_W = 16;

    // parameter numbers handled here
    localparam logic [15:0] PAG_P_WRITE_POLICY  = 16'h004D;  // 77
    localparam logic [15:0] PAG_P_DIR_LIMIT     = 16'h004E;  // 78
    localparam logic [15:0] PAG_P_DISPLAY_SCOPE = 16'h00A0;  // 160
    localparam logic [15:0] PAG_P_STALL_LEVEL   = 16'h0016;  // 22
    localparam logic [15:0] PAG_P_RESET_SEL     = 16'h004B;  // 75
    localparam logic [15:0] PAG_P_OP_MODE       = 16'h004F;  // 79
    localparam logic [15:0] PAG_P_PW_LEVEL      = 16'h0128;  // 296
    localparam logic [15:0] PAG_P_PW_LOCK       = 16'h0129;  // 297
    localparam logic [15:0] PAG_P_SW_FREQ       = 16'h0048;  // 72
    localparam logic [15:0] PAG_P_SOFT_SW       = 16'h00F0;  // 240
    localparam logic [15:0] PAG_P_JOG_FREQ      = 16'h000F;  // 15
    localparam logic [15:0] PAG_P_JOG_RAMP      = 16'h0010;  // 16
    localparam logic [15:0] PAG_P_CONTRAST      = 16'h03DF;  // 991

    // write policy values
    localparam logic [15:0] PAG_WP_STOP_ONLY = 16'h0000;
    localparam logic [15:0] PAG_WP_LOCKED    = 16'h0001;
    localparam logic [15:0] PAG_WP_ANY       = 16'h0002;

    // direction limit values
    localparam logic [15:0] PAG_DL_BOTH   = 16'h0000;
    localparam logic [15:0] PAG_DL_NO_REV = 16'h0001;
    localparam logic [15:0] PAG_DL_NO_FWD = 16'h0002;

    // display scope values
    localparam logic [15:0] PAG_DS_EXTENDED = 16'h0000;
    localparam logic [15:0] PAG_DS_SIMPLE   = 16'h270F;

    // panel command source values
    localparam logic [15:0] PAG_PCS_AUTO   = 16'h270F;
    localparam logic [15:0] PAG_PCS_SERIAL = 16'h0002;

    // reset values
    localparam logic [15:0] PAG_RST_WRITE_POLICY  = 16'h0000;
    localparam logic [15:0] PAG_RST_DIR_LIMIT     = 16'h0000;
    localparam logic [15:0] PAG_RST_DISPLAY_SCOPE = 16'h270F;

    // requesting party codes
    localparam logic [1:0] PAG_SRC_PANEL    = 2'h0;
    localparam logic [1:0] PAG_SRC_HANDHELD = 2'h1;
    localparam logic [1:0] PAG_SRC_SERIAL   = 2'h2;

    // request kinds
    localparam logic [1:0] PAG_OP_READ      = 2'h0;
    localparam logic [1:0] PAG_OP_WRITE     = 2'h1;
    localparam logic [1:0] PAG_OP_CLEAR     = 2'h2;
    localparam logic [1:0] PAG_OP_ALL_CLEAR = 2'h3;

endpackage

// ### pag_chk.sv
// port checks for the parameter access guard
`timescale 1ns/100ps
`default_nettype none
module pag_chk
    import pag_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic [1:0]  req_op,
    input wire logic [15:0] req_param,
    input wire logic [15:0] req_wdata,
    input wire logic        forward_start_input,
    input wire logic        handheld_attached,
    input wire logic [15:0] panel_command_source_select,
    input wire logic        resp_valid,
    input wire logic        resp_ok,
    input wire logic        resp_refused,
    input wire logic        ext_clear_strobe,
    input wire logic        run_fwd,
    input wire logic        run_rev,
    input wire logic        handheld_owns_panel,
    input wire logic [15:0] write_policy,
    input wire logic [15:0] direction_limit,
    input wire logic [15:0] display_scope
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_req;
    assign wr_req = req_valid && req_op == PAG_OP_WRITE;
    one_answer_a:
        assert property (req_valid |=> resp_valid && (resp_ok != resp_refused))
        else $error("request without a single answer");
    no_answer_a:
        assert property (!req_valid |=> !resp_valid && !resp_ok && !resp_refused)
        else $error("answer without a request");
    refuse_keep_a:
        assert property (resp_refused |-> $stable(write_policy) && $stable(direction_limit)
            && $stable(display_scope)) else $error("refused write changed a setting");
    lock_clear_a:
        assert property (req_valid && req_op == PAG_OP_CLEAR && write_policy == PAG_WP_LOCKED
            |=> resp_refused && !ext_clear_strobe) else $error("clear taken while locked");
    policy_set_a:
        assert property (wr_req && req_param == PAG_P_WRITE_POLICY && req_wdata <= 16'h0002
            && display_scope == PAG_DS_EXTENDED |=> resp_ok && write_policy == $past(req_wdata))
        else $error("write policy update lost");
    scope_gate_a:
        assert property (wr_req && req_param == PAG_P_DIR_LIMIT
            && display_scope != PAG_DS_EXTENDED |=> resp_refused)
        else $error("direction limit set in simple scope");
    no_rev_a:
        assert property (direction_limit == PAG_DL_NO_REV |=> !run_rev)
        else $error("reverse run while inhibited");
    fwd_pass_a:
        assert property (forward_start_input && direction_limit == PAG_DL_BOTH |=> run_fwd)
        else $error("forward start not passed");
    hh_owner_a:
        assert property (handheld_attached && panel_command_source_select == PAG_PCS_AUTO
            |=> handheld_owns_panel) else $error("handheld not panel owner");
    cover property (resp_refused);
    cover property (run_rev);
    cover property (write_policy == PAG_WP_LOCKED);
endmodule
bind pag_guard pag_chk i_chk (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
    .req_param(req_param), .req_wdata(req_wdata), .forward_start_input(forward_start_input),
    .handheld_attached(handheld_attached),
    .panel_command_source_select(panel_command_source_select), .resp_valid(resp_valid),
    .resp_ok(resp_ok), .resp_refused(resp_refused), .ext_clear_strobe(ext_clear_strobe),
    .run_fwd(run_fwd), .run_rev(run_rev), .handheld_owns_panel(handheld_owns_panel),
    .write_policy(write_policy), .direction_limit(direction_limit),
    .display_scope(display_scope));
`default_nettype wire

// ### pag_host.sv
// request source model: panel, handheld unit or serial host
`timescale 1ns/100ps
`default_nettype none
module pag_host
    import pag_pkg::*;
(
    output var logic        req_valid,
    output var logic [1:0]  req_op,
    output var logic [1:0]  req_src,
    output var logic [15:0] req_param,
    output var logic [15:0] req_wdata
);
    initial begin
        req_valid = 1'b0;
        req_op = PAG_OP_READ;
        req_src = PAG_SRC_PANEL;
        req_param = 16'h0000;
        req_wdata = 16'h0000;
    end
    // one-cycle request, called just after a falling edge
    task automatic send(input logic [1:0] op, input logic [1:0] src, input int p, input int d);
        req_valid = 1'b1;
        req_op = op;
        req_src = src;
        req_param = 16'(p);
        req_wdata = 16'(d);
    endtask
    // released op, parameter and data lines show the inverse of the last value; source is kept
    task automatic idle();
        req_valid = 1'b0;
        req_op = ~req_op;
        req_param = ~req_param;
        req_wdata = ~req_wdata;
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the parameter access guard
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import pag_pkg::*;
;
    logic clk, rst, req_valid, simple, shaded, running, pmode, hh, own, fa, ra, ok;
    logic [1:0] req_op, req_src, op, src;
    logic [15:0] req_param, req_wdata, pcs, resp_rdata, e_rd, ewp, ewd, wp, dl, ds;
    logic [7:0] k;
    logic rv, rok, rref, ews, ecs, eacs, run_fwd, run_rev, owns;
    logic [5:0] e_st;
    logic [2:0] e_run;
    logic [31:0] e_ext;
    int seed = 97959;
    int fails = 0;
    int n_checks = 0;
    int m_wp, m_dl, m_ds, p, d;
    logic [31:0] r, r2;
    int par_t[16] = '{77, 78, 160, 22, 75, 79, 72, 240, 23, 561, 15, 991, 100, 296, 16, 77};
    int val_t[8] = '{0, 1, 2, 0, 1, 9999, 3, 5};
    pag_host i_host (.req_valid(req_valid), .req_op(req_op), .req_src(req_src),
        .req_param(req_param), .req_wdata(req_wdata));
    pag_guard i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_src(req_src), .req_param(req_param), .req_wdata(req_wdata),
        .req_param_simple(simple), .req_param_shaded(shaded), .motor_running(running),
        .panel_mode(pmode), .handheld_attached(hh), .panel_command_source_select(pcs),
        .panel_fwd_key(k[0]), .panel_rev_key(k[1]), .handheld_fwd_key(k[2]),
        .handheld_rev_key(k[3]), .forward_start_input(k[4]), .reverse_start_input(k[5]),
        .serial_fwd_cmd(k[6]), .serial_rev_cmd(k[7]), .resp_valid(rv), .resp_ok(rok),
        .resp_refused(rref), .resp_rdata(resp_rdata), .ext_write_strobe(ews),
        .ext_write_param(ewp), .ext_write_data(ewd), .ext_clear_strobe(ecs),
        .ext_all_clear_strobe(eacs), .run_fwd(run_fwd), .run_rev(run_rev),
        .handheld_owns_panel(owns), .write_policy(wp), .direction_limit(dl),
        .display_scope(ds));
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #40000;
        fails++;
        results();
    end
    initial begin
        rst = 1'b1;
        {simple, shaded, running, pmode, hh, k, pcs} = '0;
        {e_st, e_rd, e_run, e_ext} = '0;
        m_wp = 0;
        m_dl = 0;
        m_ds = 9999;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (3000) begin
            @(negedge clk);
            check("status", {rv, rok, rref, ews, ecs, eacs}, e_st);
            check("rdata", resp_rdata, e_rd);
            check("regs", {wp, dl, ds}, {16'(m_wp), 16'(m_dl), 16'(m_ds)});
            check("run", {run_fwd, run_rev, owns}, e_run);
            if (e_st[2]) check("ext", {ewp, ewd}, e_ext);
            r = $random(seed);
            r2 = $random(seed);
            {running, pmode, hh, simple} = r[3:0];
            shaded = r[4] & r[5];
            pcs = r[7:6] == 2'h0 ? 16'h0002 : (r[7:6] == 2'h1 ? 16'h0000 : 16'h270F);
            k = r[15:8] & r[23:16];
            own = pcs == 16'h270F && hh;
            fa = (own ? k[2] : k[0]) | k[4] | k[6];
            ra = (own ? k[3] : k[1]) | k[5] | k[7];
            e_run = {fa && m_dl != 2, ra && m_dl != 1, own};
            e_st = '0;
            e_rd = '0;
            if (r[24] | r[25]) begin
                p = par_t[r[29:26]];
                d = val_t[r2[10:8]];
                op = r2[4:2] == 3'h0 ? r2[1:0] : {1'b0, r2[5]};
                src = r2[7:6] == 2'h3 ? 2'h2 : r2[7:6];
                i_host.send(op, src, p, d);
                if (op == 0) begin
                    ok = simple || (hh && p inside {15, 16, 991}) || m_ds == 0
                        || (src == 2 && pcs != 16'h0002);
                    if (ok) e_rd = 16'(p == 77 ? m_wp : p == 78 ? m_dl : p == 160 ? m_ds : 0);
                end else if (op == 1) begin
                    case (m_wp)
                        0: ok = (!running && pmode) || (shaded && !(p inside {72, 240}))
                            || p inside {77, 160, 75, 296, 297} || (p inside {72, 240} && pmode);
                        1: ok = p inside {22, 75, 77, 79, 160, 296, 297};
                        default: ok = !(running && p inside {23, 79, 561});
                    endcase
                    if (p == 77) ok = 1'b1;
                    if (p inside {77, 78} && (m_ds != 0 || d > 2)) ok = 1'b0;
                    if (p == 160 && d != 0 && d != 9999) ok = 1'b0;
                    if (ok) begin
                        if (p == 77) m_wp = d;
                        else if (p == 78) m_dl = d;
                        else if (p == 160) m_ds = d;
                        else begin
                            e_st[2] = 1'b1;
                            e_ext = {16'(p), 16'(d)};
                        end
                    end
                end else begin
                    ok = m_wp != 1 && !(op == 3 && running);
                    if (ok) begin
                        m_dl = 0;
                        m_ds = 9999;
                        e_st[3 - op] = 1'b1;
                    end
                end
                e_st[5:3] = {1'b1, ok, !ok};
            end else begin
                i_host.idle();
            end
        end
        results();
    end
endmodule
`default_nettype wire
